// ### core/dmaur_pkg.sv
// Constants for the upper-channel DMA register front end
// Operation
// - Processor reset clears every bit of the all-channels request mask.
// - Mask bit n masks request line n (0 to 3) when set; bits 7 to 4 read as zero.
// - Reading an address register returns the current address low byte at pointer 0, high at 1.
// - Writing an address register loads base and current address, low byte at 0, high at 1.
// - Reading a count register returns the current count low byte at pointer 0, high at 1.
// - Writing a count register loads base and current count, low byte at 0, high at 1.
// - Channel 4 address register sits at 0C0H and its count register at 0C2H.
// - Channel 5 address register sits at 0C4H and its count register at 0C6H.
// - Channel 6 address register sits at 0C8H and its count register at 0CAH.
// - Channel 7 address register sits at 0CCH and its count register at 0CEH.
// - Location 0D0H reads status and writes command, whatever the byte pointer.
// - A write to the clear-pointer location forces the pointer to 0, data ignored.
package dmaur_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NCH = 4;
  localparam int AW  = 16;

  // ----------------------------------------
  // I/O locations
  // ----------------------------------------
  localparam logic [7:0] CH4_ADDR_OFS = 8'hC0;
  localparam logic [7:0] CH4_CNT_OFS  = 8'hC2;
  localparam logic [7:0] CH5_ADDR_OFS = 8'hC4;
  localparam logic [7:0] CH5_CNT_OFS  = 8'hC6;
  localparam logic [7:0] CH6_ADDR_OFS = 8'hC8;
  localparam logic [7:0] CH6_CNT_OFS  = 8'hCA;
  localparam logic [7:0] CH7_ADDR_OFS = 8'hCC;
  localparam logic [7:0] CH7_CNT_OFS  = 8'hCE;
  localparam logic [7:0] STAT_CMD_OFS = 8'hD0;
  localparam logic [7:0] CLR_PTR_OFS  = 8'hD8;
  localparam logic [7:0] MASK_ALL_OFS = 8'hDE;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int         MASK_W       = 4;
  localparam logic [3:0] MASK_RST     = 4'h0;
  localparam logic [7:0] CMD_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;
  localparam logic [AW-1:0] REG_RST   = 16'h0000;

  // ----------------------------------------
  // Byte pointer
  // ----------------------------------------
  localparam logic PTR_LOW  = 1'b0;
  localparam logic PTR_HIGH = 1'b1;

endpackage

// ### core/dmaur_reg_if.sv
// Carrier between the decoder and the channel register store
`timescale 1ns/10ps
interface dmaur_reg_if #(
  parameter int NCH = 4,
  parameter int AW  = 16
);
  logic                    host_we;
  logic                    sel_cnt;
  logic [1:0]              chan;
  logic                    hi;
  logic [7:0]              wdata;
  logic                    eng_we;
  logic [1:0]              eng_chan;
  logic [AW-1:0]           eng_addr;
  logic [AW-1:0]           eng_cnt;
  logic [NCH-1:0][AW-1:0]  cur_addr;
  logic [NCH-1:0][AW-1:0]  cur_cnt;
  logic [NCH-1:0][AW-1:0]  base_addr;
  logic [NCH-1:0][AW-1:0]  base_cnt;

  modport ctrl (
    output host_we, sel_cnt, chan, hi, wdata,
    output eng_we, eng_chan, eng_addr, eng_cnt,
    input  cur_addr, cur_cnt, base_addr, base_cnt
  );
  modport store (
    input  host_we, sel_cnt, chan, hi, wdata,
    input  eng_we, eng_chan, eng_addr, eng_cnt,
    output cur_addr, cur_cnt, base_addr, base_cnt
  );
endinterface

// ### core/dmaur_chan_store.sv
// Base and current address and count registers of the four channels
`timescale 1ns/10ps
module dmaur_chan_store #(
  parameter int NCH = dmaur_pkg::NCH,
  parameter int AW  = dmaur_pkg::AW
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Decoder side
  dmaur_reg_if.store rif
);

  typedef struct packed {
    logic [NCH-1:0][AW-1:0] base_addr;
    logic [NCH-1:0][AW-1:0] cur_addr;
    logic [NCH-1:0][AW-1:0] base_cnt;
    logic [NCH-1:0][AW-1:0] cur_cnt;
  } dmaur_store_t;

  dmaur_store_t st_r;
  dmaur_store_t st_nxt;

  // Engine updates first, host byte writes take precedence
  always_comb
  begin
    st_nxt = st_r;
    for (int c = 0; c < NCH; c++)
    begin
      if (rif.eng_we && rif.eng_chan == c[1:0])
      begin
        st_nxt.cur_addr[c] = rif.eng_addr;
        st_nxt.cur_cnt[c]  = rif.eng_cnt;
      end
      if (rif.host_we && rif.chan == c[1:0])
      begin
        if (!rif.sel_cnt)
        begin
          if (rif.hi)
          begin
            st_nxt.base_addr[c][15:8] = rif.wdata;
            st_nxt.cur_addr[c][15:8]  = rif.wdata;
          end
          else
          begin
            st_nxt.base_addr[c][7:0] = rif.wdata;
            st_nxt.cur_addr[c][7:0]  = rif.wdata;
          end
        end
        else if (rif.hi)
        begin
          st_nxt.base_cnt[c][15:8] = rif.wdata;
          st_nxt.cur_cnt[c][15:8]  = rif.wdata;
        end
        else
        begin
          st_nxt.base_cnt[c][7:0] = rif.wdata;
          st_nxt.cur_cnt[c][7:0]  = rif.wdata;
        end
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Register views
  assign rif.cur_addr  = st_r.cur_addr;
  assign rif.cur_cnt   = st_r.cur_cnt;
  assign rif.base_addr = st_r.base_addr;
  assign rif.base_cnt  = st_r.base_cnt;

endmodule

// ### core/dmaur_regs.sv
// Upper-channel DMA register front end: decode, byte pointer, mask, command
`timescale 1ns/10ps
module dmaur_regs #(
  parameter int NCH = dmaur_pkg::NCH,
  parameter int AW  = dmaur_pkg::AW
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   nrst_i,
  // Host byte-wide I/O port
  input  wire logic [7:0]             io_addr_i,
  input  wire logic [7:0]             io_wdata_i,
  input  wire logic                   io_rd_i,
  input  wire logic                   io_wr_i,
  output logic      [7:0]             io_rdata_o,
  output logic                        io_rvalid_o,
  // Status source and its read strobe
  input  wire logic [7:0]             status_i,
  output logic                        status_rd_o,
  // Transfer engine updates
  input  wire logic                   eng_we_i,
  input  wire logic [1:0]             eng_chan_i,
  input  wire logic [AW-1:0]          eng_addr_i,
  input  wire logic [AW-1:0]          eng_cnt_i,
  // Register contents toward the engine
  output logic      [NCH-1:0][AW-1:0] cur_addr_o,
  output logic      [NCH-1:0][AW-1:0] cur_cnt_o,
  output logic      [NCH-1:0][AW-1:0] base_addr_o,
  output logic      [NCH-1:0][AW-1:0] base_cnt_o,
  output logic      [7:0]             command_o,
  output logic      [3:0]             req_mask_o,
  output logic                        byte_ptr_o
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (NCH != 4 || AW != 16)
  begin : g_bad_size
    $error("dmaur_regs serves exactly four 16-bit channels");
  end
  if (dmaur_pkg::MASK_W != 4)
  begin : g_bad_mask
    $error("dmaur_regs keeps a four-bit request mask");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic       ptr;
    logic [3:0] mask;
    logic [7:0] cmd;
    logic [7:0] rdata;
    logic       rvalid;
  } dmaur_state_t;

  dmaur_state_t st_r;
  dmaur_state_t st_nxt;

  // Decode results
  logic       hit_chan;
  logic       hit_stat;
  logic       hit_clr;
  logic       hit_mask;
  logic [1:0] dec_chan;
  logic       dec_cnt;
  logic       ptr_nxt;

  // Read path
  logic [AW-1:0] rd_word;
  logic [7:0]    rd_byte;

  dmaur_reg_if #(.NCH(NCH), .AW(AW)) rif ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Each even channel location names one channel and one register kind
  always_comb
  begin
    hit_chan = 1'b0;
    hit_stat = 1'b0;
    hit_clr  = 1'b0;
    hit_mask = 1'b0;
    dec_chan = 2'h0;
    dec_cnt  = 1'b0;
    if (io_addr_i == dmaur_pkg::CH4_ADDR_OFS)
    begin
      hit_chan = 1'b1;
      dec_chan = 2'h0;
      dec_cnt  = 1'b0;
    end
    else if (io_addr_i == dmaur_pkg::CH4_CNT_OFS)
    begin
      hit_chan = 1'b1;
      dec_chan = 2'h0;
      dec_cnt  = 1'b1;
    end
    else if (io_addr_i == dmaur_pkg::CH5_ADDR_OFS)
    begin
      hit_chan = 1'b1;
      dec_chan = 2'h1;
      dec_cnt  = 1'b0;
    end
    else if (io_addr_i == dmaur_pkg::CH5_CNT_OFS)
    begin
      hit_chan = 1'b1;
      dec_chan = 2'h1;
      dec_cnt  = 1'b1;
    end
    else if (io_addr_i == dmaur_pkg::CH6_ADDR_OFS)
    begin
      hit_chan = 1'b1;
      dec_chan = 2'h2;
      dec_cnt  = 1'b0;
    end
    else if (io_addr_i == dmaur_pkg::CH6_CNT_OFS)
    begin
      hit_chan = 1'b1;
      dec_chan = 2'h2;
      dec_cnt  = 1'b1;
    end
    else if (io_addr_i == dmaur_pkg::CH7_ADDR_OFS)
    begin
      hit_chan = 1'b1;
      dec_chan = 2'h3;
      dec_cnt  = 1'b0;
    end
    else if (io_addr_i == dmaur_pkg::CH7_CNT_OFS)
    begin
      hit_chan = 1'b1;
      dec_chan = 2'h3;
      dec_cnt  = 1'b1;
    end
    else if (io_addr_i == dmaur_pkg::STAT_CMD_OFS)
    begin
      hit_stat = 1'b1;
    end
    else if (io_addr_i == dmaur_pkg::CLR_PTR_OFS)
    begin
      hit_clr = 1'b1;
    end
    else if (io_addr_i == dmaur_pkg::MASK_ALL_OFS)
    begin
      hit_mask = 1'b1;
    end
  end

  // ----------------------------------------
  // Register store link
  // ----------------------------------------
  // Host writes go to the store with the pointer picking the byte
  assign rif.host_we  = io_wr_i && hit_chan;
  assign rif.sel_cnt  = dec_cnt;
  assign rif.chan     = dec_chan;
  assign rif.hi       = st_r.ptr;
  assign rif.wdata    = io_wdata_i;
  assign rif.eng_we   = eng_we_i;
  assign rif.eng_chan = eng_chan_i;
  assign rif.eng_addr = eng_addr_i;
  assign rif.eng_cnt  = eng_cnt_i;

  dmaur_chan_store #(
    .NCH (NCH),
    .AW  (AW)
  ) u_store (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .rif       (rif.store)
  );

  // ----------------------------------------
  // Byte pointer
  // ----------------------------------------
  // Channel reads and writes each flip it; a read and a write at once cancel out
  always_comb
  begin
    ptr_nxt = st_r.ptr;
    if (hit_chan && io_rd_i)
    begin
      ptr_nxt = ~ptr_nxt;
    end
    if (hit_chan && io_wr_i)
    begin
      ptr_nxt = ~ptr_nxt;
    end
    if (hit_clr && io_wr_i)
    begin
      ptr_nxt = dmaur_pkg::PTR_LOW;
    end
  end

  // ----------------------------------------
  // Read byte select
  // ----------------------------------------
  // The pointer picks a byte of the current value, never of the base
  always_comb
  begin
    rd_word = rif.cur_addr[dec_chan];
    if (dec_cnt)
    begin
      rd_word = rif.cur_cnt[dec_chan];
    end
    if (st_r.ptr == dmaur_pkg::PTR_HIGH)
    begin
      rd_byte = rd_word[15:8];
    end
    else
    begin
      rd_byte = rd_word[7:0];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Read data, command and mask follow the strobes
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = io_rd_i;
    st_nxt.ptr    = ptr_nxt;
    // Reads
    if (io_rd_i)
    begin
      if (hit_chan)
      begin
        st_nxt.rdata = rd_byte;
      end
      else if (hit_stat)
      begin
        st_nxt.rdata = status_i;
      end
      else if (hit_mask)
      begin
        st_nxt.rdata = {4'h0, st_r.mask};
      end
      else
      begin
        st_nxt.rdata = dmaur_pkg::UNMAPPED_RD;
      end
    end
    // Writes
    if (io_wr_i)
    begin
      if (hit_stat)
      begin
        st_nxt.cmd = io_wdata_i;
      end
      else if (hit_mask)
      begin
        st_nxt.mask = io_wdata_i[3:0];
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      st_r.ptr    <= dmaur_pkg::PTR_LOW;
      st_r.mask   <= dmaur_pkg::MASK_RST;
      st_r.cmd    <= dmaur_pkg::CMD_RST;
      st_r.rdata  <= dmaur_pkg::UNMAPPED_RD;
      st_r.rvalid <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Host port
  assign io_rdata_o  = st_r.rdata;
  assign io_rvalid_o = st_r.rvalid;
  assign status_rd_o = io_rd_i && hit_stat; // Lets status clear its sticky bits

  // Control state
  assign command_o   = st_r.cmd;
  assign req_mask_o  = st_r.mask;
  assign byte_ptr_o  = st_r.ptr;

  // Channel registers straight from the store
  assign cur_addr_o  = rif.cur_addr;
  assign cur_cnt_o   = rif.cur_cnt;
  assign base_addr_o = rif.base_addr;
  assign base_cnt_o  = rif.base_cnt;

endmodule

// ### bench/dmaur_regs_properties.sv
// Port checks for the upper-channel DMA register front end
`timescale 1ns/10ps
module dmaur_regs_properties (
  // Clock and reset
  input wire logic             sys_clk_i,
  input wire logic             nrst_i,
  // Host port
  input wire logic [7:0]       io_addr_i,
  input wire logic [7:0]       io_wdata_i,
  input wire logic             io_rd_i,
  input wire logic             io_wr_i,
  input wire logic [7:0]       io_rdata_o,
  input wire logic             io_rvalid_o,
  input wire logic [7:0]       status_i,
  input wire logic             status_rd_o,
  // Register contents
  input wire logic [3:0][15:0] cur_addr_o,
  input wire logic [3:0][15:0] base_addr_o,
  input wire logic [3:0][15:0] cur_cnt_o,
  input wire logic [7:0]       command_o,
  input wire logic [3:0]       req_mask_o,
  input wire logic             byte_ptr_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Access to an even channel location, which moves the pointer
  logic chan_acc;
  assign chan_acc = (io_rd_i | io_wr_i) & (io_addr_i[7:4] == 4'hC) & ~io_addr_i[0];

  a_mask_reset: assert property (disable iff (1'b0)
    !nrst_i |=> req_mask_o == 4'h0) else $error("mask kept through reset");
  a_mask_write: assert property (
    io_wr_i && io_addr_i == 8'hDE |=> req_mask_o == $past(io_wdata_i[3:0]))
    else $error("mask write lost");
  a_mask_read: assert property (
    io_rd_i && io_addr_i == 8'hDE |=> io_rdata_o == {4'h0, $past(req_mask_o)})
    else $error("mask read wrong");
  a_addr_high_load: assert property (
    io_wr_i && io_addr_i == 8'hC0 && byte_ptr_o |=> cur_addr_o[0][15:8] == $past(io_wdata_i)
    && base_addr_o[0][15:8] == $past(io_wdata_i)) else $error("address high byte not loaded");
  a_count_read: assert property (
    io_rd_i && io_addr_i == 8'hC2 |=> io_rdata_o == ($past(byte_ptr_o) ?
    $past(cur_cnt_o[0][15:8]) : $past(cur_cnt_o[0][7:0]))) else $error("count byte wrong");
  a_status_strobe: assert property (
    status_rd_o == (io_rd_i && io_addr_i == 8'hD0)) else $error("status strobe wrong");
  a_status_data: assert property (
    io_rd_i && io_addr_i == 8'hD0 |=> io_rvalid_o && io_rdata_o == $past(status_i)
    && $stable(byte_ptr_o)) else $error("status read wrong");
  a_command_load: assert property (
    io_wr_i && io_addr_i == 8'hD0 |=> command_o == $past(io_wdata_i) && $stable(byte_ptr_o))
    else $error("command write wrong");
  a_ptr_clear: assert property (
    io_wr_i && io_addr_i == 8'hD8 |=> !byte_ptr_o) else $error("pointer not cleared");
  a_ptr_toggle: assert property (
    chan_acc |=> byte_ptr_o != $past(byte_ptr_o)) else $error("pointer not toggled");
  // Main scenarios reached
  c_clear: cover property (io_wr_i && io_addr_i == 8'hD8);
  c_status: cover property (io_rd_i && io_addr_i == 8'hD0);
  c_mask: cover property (io_wr_i && io_addr_i == 8'hDE);
endmodule

// ### bench/dmaur_host.sv
// Host processor model issuing byte-wide I/O cycles
`timescale 1ns/10ps
module dmaur_host (
  // Clock
  input  wire logic       sys_clk_i,
  // I/O cycle toward the device
  output logic      [7:0] io_addr_o,
  output logic      [7:0] io_wdata_o,
  output logic            io_rd_o,
  output logic            io_wr_o
);
  logic [7:0] exp_q[$];
  // Idle bus at time zero
  initial
  begin
    io_addr_o = 8'h00;
    io_wdata_o = 8'h00;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
  end
  // One strobe cycle from falling edge to falling edge; data inverted once released
  task automatic strobe(input logic [7:0] a, input logic [7:0] d, input logic rd);
    @(negedge sys_clk_i);
    io_addr_o = a;
    io_wdata_o = d;
    io_rd_o = rd;
    io_wr_o = ~rd;
    @(negedge sys_clk_i);
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_wdata_o = ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    strobe(a, d, 1'b0);
  endtask
  // Read; the expected byte is noted before the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    strobe(a, ~e, 1'b1);
  endtask
  // Pointer cleared first, then low and high byte
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(8'hD8, v[15:8]);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] v);
    wr(8'hD8, v[7:0]);
    rd(a, v[7:0]);
    rd(a, v[15:8]);
  endtask
endmodule

// ### bench/tb.sv
// Self-checking bench for the upper-channel DMA register front end
`timescale 1ns/10ps
module tb;
  logic             sys_clk_i;
  logic             nrst_i;
  logic [7:0]       status_i;
  logic [7:0]       io_addr, io_wdata, io_rdata, command, rng;
  logic             io_rd, io_wr, io_rvalid, byte_ptr;
  logic [3:0][15:0] cur_addr, cur_cnt, base_addr, base_cnt;
  logic [3:0]       req_mask;
  logic [15:0]      val;
  logic             eng_we;
  logic [1:0]       eng_chan;
  logic [15:0]      eng_addr, eng_cnt;
  int               bad_count, compares, cyc;

  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  dmaur_host host (.sys_clk_i(sys_clk_i), .io_addr_o(io_addr), .io_wdata_o(io_wdata),
    .io_rd_o(io_rd), .io_wr_o(io_wr));
  // Engine update port driven by the bench between host cycles
  dmaur_regs DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .io_addr_i(io_addr),
    .io_wdata_i(io_wdata), .io_rd_i(io_rd), .io_wr_i(io_wr), .io_rdata_o(io_rdata),
    .io_rvalid_o(io_rvalid), .status_i(status_i), .status_rd_o(), .eng_we_i(eng_we),
    .eng_chan_i(eng_chan), .eng_addr_i(eng_addr), .eng_cnt_i(eng_cnt), .cur_addr_o(cur_addr),
    .cur_cnt_o(cur_cnt), .base_addr_o(base_addr), .base_cnt_o(base_cnt),
    .command_o(command), .req_mask_o(req_mask), .byte_ptr_o(byte_ptr));

  function automatic logic [7:0] rnd();
    rng = {rng[6:0], rng[7] ^ rng[5] ^ rng[4] ^ rng[3]};
    return rng;
  endfunction
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Each read result against the oldest note
  always @(negedge sys_clk_i)
    if (io_rvalid === 1'b1)
      check("read", io_rdata, host.exp_q.size() ? host.exp_q.pop_front() : 8'hXX);
  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  initial
  begin
    nrst_i = 1'b0;
    status_i = 8'h00;
    eng_we = 1'b0;
    eng_chan = 2'h0;
    eng_addr = 16'h0000;
    eng_cnt = 16'h0000;
    rng = 8'h60;
    bad_count = 0;
    compares = 0;
    cyc = 0;
    repeat (10) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    check("reset mask", req_mask, 16'h0000);
    // All eight channel registers: write, outputs, read back
    for (int i = 0; i < 8; i++)
    begin
      val = {rnd(), rnd()};
      host.wr16(8'hC0 + 8'(2 * i), val);
      check("current", i[0] ? cur_cnt[i / 2] : cur_addr[i / 2], val);
      check("base", i[0] ? base_cnt[i / 2] : base_addr[i / 2], val);
      host.rd16(8'hC0 + 8'(2 * i), val);
    end
    // Engine moves channel 5 on: reads show the current value, base stays as written
    host.wr16(8'hC4, val);
    @(negedge sys_clk_i);
    eng_chan = 2'h1;
    eng_addr = ~val;
    eng_cnt = {rnd(), rnd()};
    eng_we = 1'b1;
    @(negedge sys_clk_i);
    eng_we = 1'b0;
    check("engine base", base_addr[1], val);
    check("engine current", cur_addr[1], eng_addr);
    host.rd16(8'hC4, eng_addr);
    host.rd16(8'hC6, eng_cnt);
    // Pointer against status, command and clear
    host.wr(8'hD8, rnd());
    host.wr(8'hC4, 8'h5A);
    check("pointer", byte_ptr, 16'h0001);
    status_i = rnd();
    host.rd(8'hD0, status_i);
    host.wr(8'hD0, 8'hA5);
    check("command", command, 16'h00A5);
    check("pointer kept", byte_ptr, 16'h0001);
    host.wr(8'hD8, 8'hFF);
    check("pointer clear", byte_ptr, 16'h0000);
    // Mask write, reserved bits, odd location, reset in mid-run
    host.wr(8'hDE, 8'hFF);
    check("mask", req_mask, 16'h000F);
    host.rd(8'hDE, 8'h0F);
    host.rd(8'hC1, 8'h00);
    nrst_i = 1'b0;
    @(negedge sys_clk_i);
    nrst_i = 1'b1;
    check("mask reset", req_mask, 16'h0000);
    host.rd16(8'hC6, 16'h0000);
    repeat (2) @(negedge sys_clk_i);
    check("notes left", 16'(host.exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule

bind dmaur_regs dmaur_regs_properties u_props (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
  .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .status_i(status_i),
  .status_rd_o(status_rd_o), .cur_addr_o(cur_addr_o), .base_addr_o(base_addr_o),
  .cur_cnt_o(cur_cnt_o), .command_o(command_o), .req_mask_o(req_mask_o),
  .byte_ptr_o(byte_ptr_o));
